/* logic/pin_function_map.svh */
`ifndef PIN_FUNCTION_MAP_SVH
`define PIN_FUNCTION_MAP_SVH

// Register byte offsets
`define REG_PIO_MODE      8'h00
`define REG_PIO_DIR       8'h04
`define REG_PIO_DATA      8'h08
`define REG_PIO_PIN       8'h0C
`define REG_AUX_CONTROL   8'h10
`define REG_STRAP_STATUS  8'h14
`define REG_PIO_PULL      8'h18

// Auxiliary control field positions
`define AUX_SEND_SELECT_BIT  0
`define AUX_FLOW_CTRL_BIT    1
`define AUX_DEMOD_BIT        2
`define AUX_UPPER_WIDTH_BIT  3

// Strap status field positions
`define STRAP_BOOT16_BIT     0
`define STRAP_HALVE_BIT      1
`define STRAP_ADDR_EN_BIT    2

// Reset values: 1 in mode = pin used as programmable io
`define PIO_MODE_RESET   32'hFFFF_FC0F
`define PIO_DIR_RESET    32'h0000_0000
`define PIO_DATA_RESET   32'h0000_0000
// 1 in pull = pull-down selected
`define PIO_PULL_RESET   32'h0000_0402
`define AUX_RESET        4'h0

// Pin indices
`define PIN_TIMER1_INPUT       5'd0
`define PIN_TIMER1_OUTPUT      5'd1
`define PIN_SYNC_READY   5'd6
`define PIN_TIMER0_OUTPUT      5'd10
`define PIN_TIMER0_INPUT       5'd11
`define PIN_UPPER_ZERO   5'd26
`define PIN_DMA_STATUS   5'd29
// Pins whose only pull is pull-up (4,5,7,8,9)
`define PULLUP_ONLY_MASK 32'h0000_03B0

// Bus cycle status codes
`define STAT_INTA   3'h0
`define STAT_IORD   3'h1
`define STAT_IOWR   3'h2
`define STAT_HALT   3'h3
`define STAT_FETCH  3'h4
`define STAT_MEMRD  3'h5
`define STAT_MEMWR  3'h6
`define STAT_IDLE   3'h7

`endif

/* logic/pin_function_pkg.sv */
package pin_function_pkg;

   typedef enum logic [2:0] {
      cyc_inta,
      cyc_io_read,
      cyc_io_write,
      cyc_halt,
      cyc_fetch,
      cyc_mem_read,
      cyc_mem_write,
      cyc_idle
   } cycle_kind_e;

   typedef enum logic [1:0] {
      per_t1,
      per_t2,
      per_t3,
      per_t4
   } bus_period_e;

   typedef struct packed {
      cycle_kind_e kind;
      bus_period_e period;
      logic dma;
      logic hold;
   } bus_cycle_s;

   typedef struct packed {
      logic tx_pending;
      logic rx_unread;
   } serial_state_s;

   typedef struct packed {
      logic [2:0] status;
      logic status_oe;
      logic dma_status;
      logic dma_status_oe;
   } status_pins_s;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
   } pad_drive_s;

endpackage

/* logic/pin_sync2.sv */
`timescale 1ns/1ns
// Two-stage synchroniser, one per bit
module pin_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_s;

   sync_state_s state;
   sync_state_s next_state;

   always_comb begin
      next_state.meta = d;
      next_state.sync = state.meta;
   end

   // No reset: strap levels must flush through while reset is still held
   always_ff @(posedge aclk) begin
      state <= next_state;
   end

   assign q = state.sync;

endmodule

/* logic/timer_input_stage.sv */
`timescale 1ns/1ns
// Timer input selection and rising-edge increment pulses
module timer_input_stage (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Synchronised pin levels
   input wire logic timer0_pin_sync,
   input wire logic timer1_pin_sync,
   input wire logic demod_pin_sync,
   // Configuration
   input wire logic timer0_pin_is_pio,
   input wire logic timer1_pin_is_pio,
   input wire logic pulse_width_demod_mode,
   // Increment pulses
   output logic timer0_increment,
   output logic timer1_increment
);

   typedef struct packed {
      logic last0;
      logic last1;
      logic inc0;
      logic inc1;
   } edge_state_s;

   edge_state_s state;
   edge_state_s next_state;
   logic level0;
   logic level1;

   always_comb begin
      // Demod routing wins over pio pull-high
      if (pulse_width_demod_mode) begin
         level0 = demod_pin_sync;
         level1 = demod_pin_sync;
      end else begin
         level0 = timer0_pin_is_pio ? 1'b1 : timer0_pin_sync;
         level1 = timer1_pin_is_pio ? 1'b1 : timer1_pin_sync;
      end
      next_state.last0 = level0;
      next_state.last1 = level1;
      next_state.inc0 = level0 & ~state.last0;
      next_state.inc1 = level1 & ~state.last1;
   end

   // Held-high reset level avoids a spurious count at release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '{last0: 1'b1, last1: 1'b1, inc0: 1'b0, inc1: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign timer0_increment = state.inc0;
   assign timer1_increment = state.inc1;

endmodule

/* logic/pin_function_and_strap_logic.sv */
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "pin_function_map.svh"
module pin_function_and_strap_logic (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side bus cycle and serial state
   input wire pin_function_pkg::bus_cycle_s bus_cycle,
   input wire pin_function_pkg::serial_state_s serial0,
   input wire logic timer0_wave,
   input wire logic timer1_wave,
   // Pads: programmable io
   input wire logic [31:0] pad_in,
   output logic [31:0] pad_out,
   output logic [31:0] pad_oe,
   output logic [31:0] pad_pull_down,
   output logic [31:0] pad_pull_up,
   // Pads: status and strap pins
   input wire logic boot_width_strap,
   input wire logic clock_halve_strap,
   input wire logic high_byte_addr_enable_strap,
   input wire logic irq2_demod_input,
   input wire logic async_ready_in,
   output pin_function_pkg::status_pins_s status_pins,
   output logic ready_to_send_port0,
   output logic ready_to_receive_port0,
   output logic flow_pin_port0,
   output logic timer0_output,
   output logic timer0_output_oe,
   output logic timer1_output,
   output logic timer1_output_oe,
   // Core side results
   output logic boot_16bit,
   output logic upper_region_16bit,
   output logic clock_halved,
   output logic pll_enable,
   output logic transfer_ready,
   output logic timer0_increment,
   output logic timer1_increment
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [31:0] pio_mode;
      logic [31:0] pio_dir;
      logic [31:0] pio_data;
      logic [31:0] pio_pull;
      logic [3:0] auxiliary_control_reg;
      logic strapped;
      logic boot16;
      logic halve;
      logic addr_en;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      pin_function_pkg::status_pins_s status;
      logic rts;
      logic rtr;
   } state_s;

   state_s state;
   state_s next_state;

   logic [31:0] pad_sync;
   logic [2:0] strap_sync;
   logic demod_sync;
   logic async_ready_sync;
   logic [31:0] reverted;
   logic [31:0] pio_active;
   logic flow_on;
   logic [31:0] masked_write;
   logic [31:0] wmask;

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   pin_sync2 #(.WIDTH(32)) u_pad_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(pad_in),
      .q(pad_sync)
   );

   pin_sync2 #(.WIDTH(5)) u_strap_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({async_ready_in, irq2_demod_input, high_byte_addr_enable_strap,
          clock_halve_strap, boot_width_strap}),
      .q({async_ready_sync, demod_sync, strap_sync})
   );

   // ************************************************************
   // Timer inputs
   // ************************************************************
   timer_input_stage u_timer_in (
      .aclk(aclk),
      .aresetn(aresetn),
      .timer0_pin_sync(pad_sync[`PIN_TIMER0_INPUT]),
      .timer1_pin_sync(pad_sync[`PIN_TIMER1_INPUT]),
      .demod_pin_sync(demod_sync),
      .timer0_pin_is_pio(pio_active[`PIN_TIMER0_INPUT]),
      .timer1_pin_is_pio(pio_active[`PIN_TIMER1_INPUT]),
      .pulse_width_demod_mode(state.auxiliary_control_reg[`AUX_DEMOD_BIT]),
      .timer0_increment(timer0_increment),
      .timer1_increment(timer1_increment)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      reverted = '0;
      if (!state.addr_en) begin
         reverted[`PIN_UPPER_ZERO] = 1'b1;
         reverted[`PIN_DMA_STATUS] = 1'b1;
      end
      pio_active = state.pio_mode & ~reverted;
      flow_on = state.auxiliary_control_reg[`AUX_FLOW_CTRL_BIT];
      wmask = {{8{state.w_strb[3]}}, {8{state.w_strb[2]}},
               {8{state.w_strb[1]}}, {8{state.w_strb[0]}}};
      masked_write = '0;
      next_state = state;

      // Straps taken on the first clock after reset release
      if (!state.strapped) begin
         next_state.strapped = 1'b1;
         next_state.boot16 = strap_sync[0];
         next_state.halve = ~strap_sync[1];
         next_state.addr_en = strap_sync[2];
      end

      // Write channel capture, address and data in either order
      if (s_axi_awvalid && !state.aw_full) begin
         next_state.aw_full = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.w_full) begin
         next_state.w_full = 1'b1;
         next_state.w_data = s_axi_wdata;
         next_state.w_strb = s_axi_wstrb;
      end
      if (state.aw_full && state.w_full && !state.bvalid) begin
         next_state.aw_full = 1'b0;
         next_state.w_full = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = 2'h0;
         case (state.aw_addr)
            `REG_PIO_MODE: begin
               masked_write = (state.pio_mode & ~wmask) | (state.w_data & wmask);
               next_state.pio_mode = masked_write;
            end
            `REG_PIO_DIR: begin
               masked_write = (state.pio_dir & ~wmask) | (state.w_data & wmask);
               next_state.pio_dir = masked_write;
            end
            `REG_PIO_DATA: begin
               masked_write = (state.pio_data & ~wmask) | (state.w_data & wmask);
               next_state.pio_data = masked_write;
            end
            `REG_PIO_PULL: begin
               masked_write = (state.pio_pull & ~wmask) | (state.w_data & wmask);
               next_state.pio_pull = masked_write & ~`PULLUP_ONLY_MASK;
            end
            `REG_AUX_CONTROL: begin
               if (state.w_strb[0]) begin
                  next_state.auxiliary_control_reg[2:0] = state.w_data[2:0];
                  // Width change only allowed after an 8-bit boot
                  if (!state.boot16) begin
                     next_state.auxiliary_control_reg[`AUX_UPPER_WIDTH_BIT] =
                        state.w_data[`AUX_UPPER_WIDTH_BIT];
                  end
               end
            end
            `REG_PIO_PIN, `REG_STRAP_STATUS: begin
               next_state.bresp = 2'h0;
            end
            default: begin
               next_state.bresp = 2'h2;
            end
         endcase
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end

      // Read channel
      if (s_axi_arvalid && !state.rvalid) begin
         next_state.rvalid = 1'b1;
         next_state.rresp = 2'h0;
         case (s_axi_araddr)
            `REG_PIO_MODE: next_state.rdata = pio_active;
            `REG_PIO_DIR: next_state.rdata = state.pio_dir;
            `REG_PIO_DATA: next_state.rdata = state.pio_data;
            `REG_PIO_PIN: next_state.rdata = pad_sync;
            `REG_PIO_PULL: next_state.rdata = state.pio_pull;
            `REG_AUX_CONTROL: next_state.rdata = {28'h0000000, state.auxiliary_control_reg};
            `REG_STRAP_STATUS: next_state.rdata = {29'h00000000, state.addr_en,
                                                  state.halve, state.boot16};
            default: begin
               next_state.rdata = '0;
               next_state.rresp = 2'h2;
            end
         endcase
      end else if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end

      // Bus cycle status pins
      case (bus_cycle.kind)
         pin_function_pkg::cyc_inta: next_state.status.status = `STAT_INTA;
         pin_function_pkg::cyc_io_read: next_state.status.status = `STAT_IORD;
         pin_function_pkg::cyc_io_write: next_state.status.status = `STAT_IOWR;
         pin_function_pkg::cyc_halt: next_state.status.status = `STAT_HALT;
         pin_function_pkg::cyc_fetch: next_state.status.status = `STAT_FETCH;
         pin_function_pkg::cyc_mem_read: next_state.status.status = `STAT_MEMRD;
         pin_function_pkg::cyc_mem_write: next_state.status.status = `STAT_MEMWR;
         default: next_state.status.status = `STAT_IDLE;
      endcase
      next_state.status.status_oe = ~bus_cycle.hold;
      next_state.status.dma_status = bus_cycle.dma &&
         (bus_cycle.period != pin_function_pkg::per_t1);
      next_state.status.dma_status_oe = ~bus_cycle.hold &
         ~pio_active[`PIN_DMA_STATUS];

      // Serial port 0 flow control pin
      next_state.rts = flow_on & serial0.tx_pending;
      next_state.rtr = flow_on & ~serial0.rx_unread;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
         state.pio_mode <= `PIO_MODE_RESET;
         state.pio_dir <= `PIO_DIR_RESET;
         state.pio_data <= `PIO_DATA_RESET;
         state.pio_pull <= `PIO_PULL_RESET;
         state.auxiliary_control_reg <= `AUX_RESET;
         state.boot16 <= 1'b1;
         state.addr_en <= 1'b1;
         state.status.status <= `STAT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready = ~state.aw_full;
   assign s_axi_wready = ~state.w_full;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp = state.bresp;
   assign s_axi_arready = ~state.rvalid;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;

   // Push-pull pio drive of pio_data when enabled; pulls only while the pin is a pio input
   assign pad_out = state.pio_data;
   assign pad_oe = pio_active & state.pio_dir;
   assign pad_pull_down = pio_active & ~state.pio_dir & state.pio_pull;
   assign pad_pull_up = pio_active & ~state.pio_dir & ~state.pio_pull;

   assign status_pins = state.status;
   assign ready_to_send_port0 = state.rts;
   assign ready_to_receive_port0 = state.rtr;
   // One pin: select bit picks which meaning it carries
   assign flow_pin_port0 = state.auxiliary_control_reg[`AUX_SEND_SELECT_BIT] ?
                           state.rts : state.rtr;

   // Reset forces float via the registered strap flag low during reset
   assign timer0_output = timer0_wave;
   assign timer1_output = timer1_wave;
   assign timer0_output_oe = state.strapped & ~bus_cycle.hold &
                             ~pio_active[`PIN_TIMER0_OUTPUT];
   assign timer1_output_oe = state.strapped & ~bus_cycle.hold &
                             ~pio_active[`PIN_TIMER1_OUTPUT];

   assign boot_16bit = state.boot16;
   assign upper_region_16bit = state.boot16 |
                               state.auxiliary_control_reg[`AUX_UPPER_WIDTH_BIT];
   assign clock_halved = state.halve;
   assign pll_enable = ~state.halve;
   // Sync ready (pad_sync, ignored while pin 6 is pio) and async ready both pay two sync stages
   assign transfer_ready = pio_active[`PIN_SYNC_READY] ? async_ready_sync :
                           (pad_sync[`PIN_SYNC_READY] | async_ready_sync);

endmodule

/* testbench/pin_function_monitor.sv */
`timescale 1ns/1ns
// ****************
// Port checker
// ****************
module pin_function_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Watched ports
   input wire pin_function_pkg::bus_cycle_s bus_cycle,
   input wire pin_function_pkg::status_pins_s status_pins,
   input wire logic timer0_output_oe,
   input wire logic timer1_output_oe,
   input wire logic boot_16bit,
   input wire logic clock_halved,
   input wire logic pll_enable,
   input wire logic timer0_increment,
   input wire logic timer1_increment
);
   a_status_code: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && !$past(bus_cycle.hold) |->
      status_pins.status_oe && status_pins.status == $past(bus_cycle.kind))
      else $error("status code wrong");
   a_status_float: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(bus_cycle.hold) |-> !status_pins.status_oe)
      else $error("status driven in hold");
   a_dma_status: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && !$past(bus_cycle.hold) |-> status_pins.dma_status ==
      ($past(bus_cycle.dma) && $past(bus_cycle.period) != pin_function_pkg::per_t1))
      else $error("dma status wrong");
   a_dma_float: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(bus_cycle.hold) |-> !status_pins.dma_status_oe)
      else $error("dma status driven in hold");
   a_timer_float: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_cycle.hold |-> !timer0_output_oe && !timer1_output_oe)
      else $error("timer output driven in hold");
   a_halve_pll: assert property (@(posedge aclk) disable iff (!aresetn)
      clock_halved |-> !pll_enable)
      else $error("pll on while halved");
   // Straps only move at a reset release
   a_strap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 3) |-> $stable(boot_16bit) && $stable(clock_halved))
      else $error("strap result changed");
   a_incr0_once: assert property (@(posedge aclk) disable iff (!aresetn)
      timer0_increment |=> !timer0_increment)
      else $error("timer0 double increment");
   a_incr1_once: assert property (@(posedge aclk) disable iff (!aresetn)
      timer1_increment |=> !timer1_increment)
      else $error("timer1 double increment");
endmodule
bind pin_function_and_strap_logic pin_function_monitor u_monitor (.*);

/* testbench/ext_system.sv */
`timescale 1ns/1ns
// ****************
// Board around the pins
// ****************
module ext_system (
   // From device pads
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_oe,
   // Bench controls
   input wire logic boot8,
   input wire logic halve,
   input wire logic aden_low,
   input wire logic tin0,
   input wire logic tin1,
   input wire logic sync_ready_in,
   // To device
   output logic [31:0] pad_in,
   output logic boot_width_strap,
   output logic clock_halve_strap,
   output logic high_byte_addr_enable_strap
);
   logic [31:0] ext;
   always_comb begin
      ext = '1;
      ext[11] = tin0;
      ext[0] = tin1;
      ext[6] = sync_ready_in;
      pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
   end
   // Straps through resistors, never a rail
   assign boot_width_strap = !boot8;
   assign clock_halve_strap = !halve;
   assign high_byte_addr_enable_strap = !aden_low;
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ns
// ****************
// Bench
// ****************
module testbench;
   logic aclk = 0, aresetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, pad_in, pad_out, pad_oe;
   logic [31:0] pad_pull_down, pad_pull_up, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   pin_function_pkg::bus_cycle_s bus_cycle = 7'h70;
   pin_function_pkg::serial_state_s serial0 = 2'h0;
   pin_function_pkg::status_pins_s status_pins;
   logic timer0_wave = 0, timer1_wave = 0, irq2_demod_input = 0, async_ready_in = 0;
   logic boot_width_strap, clock_halve_strap, high_byte_addr_enable_strap;
   logic ready_to_send_port0, ready_to_receive_port0, flow_pin_port0, timer0_output;
   logic timer0_output_oe, timer1_output, timer1_output_oe, boot_16bit, transfer_ready;
   logic upper_region_16bit, clock_halved, pll_enable, timer0_increment, timer1_increment;
   logic boot8 = 0, halve = 0, aden_low = 0, tin0 = 0, tin1 = 0, sync_ready_in = 1;
   int num_errors = 0, compares = 0, cycles = 0, inc0 = 0, inc1 = 0;

   pin_function_and_strap_logic u_pin_function_and_strap_logic (.*);
   ext_system u_ext_system (.pad_out(pad_out), .pad_oe(pad_oe), .boot8(boot8),
      .halve(halve), .aden_low(aden_low), .tin0(tin0), .tin1(tin1), .sync_ready_in(sync_ready_in),
      .pad_in(pad_in), .boot_width_strap(boot_width_strap),
      .clock_halve_strap(clock_halve_strap),
      .high_byte_addr_enable_strap(high_byte_addr_enable_strap));

   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles++;
      if (timer0_increment === 1'b1) inc0++;
      if (timer1_increment === 1'b1) inc1++;
      if (cycles == 5000) begin
         num_errors++;
         summarize();
      end
   end

   task summarize();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= v; s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
   endtask
   task do_reset(input logic b8, input logic h, input logic al);
      @(posedge aclk);
      boot8 <= b8; halve <= h; aden_low <= al; aresetn <= 0;
      tick(3);
      aresetn <= 1;
      tick(3);
   endtask
   // Rising edge on one source, then count increments seen
   task tpulse(input int w, input int e0, input int e1);
      int s0, s1;
      s0 = inc0; s1 = inc1;
      @(posedge aclk);
      if (w == 0) tin0 <= 1; else if (w == 1) tin1 <= 1; else irq2_demod_input <= 1;
      tick(4);
      tin0 <= 0; tin1 <= 0; irq2_demod_input <= 0;
      tick(8);
      check("inc0", e0, inc0 - s0);
      check("inc1", e1, inc1 - s1);
   endtask

   initial begin
      do_reset(1, 1, 0);
      check("boot16", 0, boot_16bit);
      check("halved", 1, clock_halved);
      check("pll", 0, pll_enable);
      rd(8'h00); check("mode", 32'hFFFF_FC0F, d);
      rd(8'h18); check("pull", 32'h0000_0402, d);
      check("pull_down", 32'h0000_0402, pad_pull_down);
      check("pull_up", 32'hFFFF_F80D, pad_pull_up);
      wr(8'h18, 32'hFFFF_FFFF);
      rd(8'h18); check("pull", 32'hFFFF_FC4F, d);
      rd(8'h1C); check("rresp", 2'h2, r);
      check("rdata", 0, d);
      wr(8'h10, 32'h8); tick(2); check("upper", 1, upper_region_16bit);
      $display("test straps done");
      serial0 <= 2'h2; wr(8'h10, 32'h3); tick(3); check("flow", 1, flow_pin_port0);
      check("rts", 1, ready_to_send_port0);
      serial0 <= 2'h0; tick(3); check("flow", 0, flow_pin_port0);
      serial0 <= 2'h1; wr(8'h10, 32'h2); tick(3); check("flow", 0, flow_pin_port0);
      serial0 <= 2'h0; tick(3); check("flow", 1, flow_pin_port0);
      check("rtr", 1, ready_to_receive_port0);
      $display("test flow done");
      for (int k = 0; k < 8; k++) begin
         bus_cycle <= 7'(k << 4);
         tick(2);
         check("status", k, status_pins.status);
      end
      bus_cycle <= 7'h7A; tick(2); check("dma", 1, status_pins.dma_status);
      bus_cycle <= 7'h72; tick(2); check("dma", 0, status_pins.dma_status);
      tpulse(0, 0, 0);
      wr(8'h00, 32'hFFFF_F00C);
      timer0_wave <= 1; tick(2); check("t0oe", 1, timer0_output_oe);
      check("t0", 1, timer0_output);
      bus_cycle <= 7'h71; tick(2); check("soe", 0, status_pins.status_oe);
      check("doe", 0, status_pins.dma_status_oe);
      check("t1oe", 0, timer1_output_oe);
      wr(8'h08, 32'h0000_1000); wr(8'h04, 32'h0000_1000); tick(2);
      check("pad_oe", 32'h0000_1000, pad_oe);
      check("pad_out", 32'h0000_1000, pad_out);
      rd(8'h0C); check("pins", 32'hFFFF_F7FE, d);
      bus_cycle <= 7'h70;
      $display("test status done");
      tpulse(0, 1, 0);
      tpulse(1, 0, 1);
      wr(8'h10, 32'h4);
      tpulse(2, 1, 1);
      tpulse(0, 0, 0);
      sync_ready_in <= 0; tick(4); check("ready", 0, transfer_ready);
      sync_ready_in <= 1; tick(4); check("ready", 1, transfer_ready);
      $display("test timers done");
      do_reset(0, 0, 1);
      check("boot16", 1, boot_16bit);
      check("pll", 1, pll_enable);
      rd(8'h00); check("mode", 32'hDBFF_FC0F, d);
      check("doe", 1, status_pins.dma_status_oe);
      $display("test second reset done");
      summarize();
   end
endmodule
